// ---- hdl/cmcm_config_map_crc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmcm_config_map_crc_monitor (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hardRstN,
  input  wire logic        modulatorClock,
  input  wire logic        enInt,
  input  wire logic        readyPulseN,
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [23:0] wrData,
  input  wire logic [23:0] mapData,
  output logic      [4:0]  mapAddr,
  output logic      [23:0] lockAndConfigChecksum,
  output logic             mapLocked,
  output logic             mismatch,
  output logic             dataReadyN
);
  logic [7:0]  lockField;
  logic [15:0] configChecksum;
  logic [15:0] refValue;
  logic        refValid;
  logic [4:0]  slot;
  logic [15:0] crcOut;

  // Power-on and hard reset act alike on everything here
  wire logic rstAny = !nrst || !hardRstN;

  wire logic lockWrite = wrEn && (wrAddr == cmcm_pkg::ADDR_LOCK);
  wire logic [7:0] next_lockField = lockWrite ? wrData[cmcm_pkg::LOCK_LSB +: 8] : lockField;
  wire logic locked = (lockField != cmcm_pkg::LOCK_KEY);
  wire logic next_locked = (next_lockField != cmcm_pkg::LOCK_KEY);

  // A processed write to 0x1F restarts the pass, so it is never a silent change
  wire logic running = locked && !lockWrite;
  wire logic tick = modulatorClock && running;
  wire logic foldSlot = (slot < cmcm_pkg::NUM_REGS);
  wire logic publish = tick && (slot == cmcm_pkg::PUBLISH_SLOT);
  wire logic stepCrc = tick && foldSlot;
  wire logic clearCrc = !running || publish;

  wire logic [4:0] next_slot = !running ? 5'h00 :
                               publish ? 5'h00 :
                               tick ? 5'(slot + 5'h01) : slot;

  // Slots after the last register park on 0x1F and fold nothing
  function automatic logic [4:0] slotAddr(input logic [4:0] s);
    logic [4:0] a;
    a = cmcm_pkg::ADDR_LOCK;
    if (s < cmcm_pkg::NUM_REGS) begin
      a = 5'(cmcm_pkg::ADDR_FIRST + s);
    end
    return a;
  endfunction

  wire logic [4:0] next_mapAddr = slotAddr(next_slot);

  // Volatile fields are replaced so the reference stays stable
  wire logic isLockReg = (mapAddr == cmcm_pkg::ADDR_LOCK);
  wire logic isStatusReg = (mapAddr == cmcm_pkg::ADDR_STATUS_COMM);
  wire logic [23:0] msgWord = isLockReg ? {lockField, 16'h0000} :
                              isStatusReg ? (mapData | cmcm_pkg::READY_MASK) :
                              mapData;

  wire logic differs = refValid && (crcOut != refValue);
  wire logic raise = publish && differs && enInt;
  wire logic next_mismatch = !next_locked ? 1'b0 : (mismatch || raise);
  wire logic [15:0] next_checksum = !next_locked ? 16'h0000 :
                                    publish ? crcOut : configChecksum;
  wire logic captureRef = publish && !refValid;
  wire logic next_refValid = next_locked && (refValid || captureRef) && !lockWrite;
  wire logic next_dataReadyN = next_mismatch ? 1'b0 : readyPulseN;

  cmcm_crc_engine #(
    .WIDTH (cmcm_pkg::REG_WIDTH)
  ) cmcm_crc_engine_i (
    .mclk  (mclk),
    .nrst  (!rstAny),
    .clear (clearCrc),
    .step  (stepCrc),
    .word  (msgWord),
    .crc   (crcOut)
  );

  always_ff @(posedge mclk) begin
    if (rstAny) begin
      lockField <= cmcm_pkg::LOCK_KEY;
      configChecksum <= cmcm_pkg::CHECKSUM_RESET;
    end else begin
      lockField <= next_lockField;
      configChecksum <= next_checksum;
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAny) begin
      refValue <= cmcm_pkg::CRC_INIT;
      refValid <= 1'b0;
    end else begin
      refValid <= next_refValid;
      if (captureRef) begin
        refValue <= crcOut;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAny) begin
      slot <= 5'h00;
      mapAddr <= cmcm_pkg::ADDR_FIRST;
    end else begin
      slot <= next_slot;
      mapAddr <= next_mapAddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAny) begin
      mismatch <= 1'b0;
      dataReadyN <= 1'b1;
      mapLocked <= 1'b0;
      lockAndConfigChecksum <= {cmcm_pkg::LOCK_KEY, cmcm_pkg::CHECKSUM_RESET};
    end else begin
      mismatch <= next_mismatch;
      dataReadyN <= next_dataReadyN;
      mapLocked <= next_locked;
      lockAndConfigChecksum <= {next_lockField, next_checksum};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rstAny);

  sequence sPublish;
    publish;
  endsequence

  sequence sPublishBad;
    publish && refValid && (crcOut != refValue) && enInt;
  endsequence

  sequence sUnlockWrite;
    lockWrite && (wrData[cmcm_pkg::LOCK_LSB +: 8] == cmcm_pkg::LOCK_KEY);
  endsequence

  sequence sRelockWrite;
    lockWrite && (wrData[cmcm_pkg::LOCK_LSB +: 8] != cmcm_pkg::LOCK_KEY);
  endsequence

  sequence sQuietCycle;
    !rstAny ##1 !mismatch;
  endsequence

  // Helper: ticks seen since the last publish or restart
  logic [5:0] tickCount;
  always_ff @(posedge mclk) begin
    if (rstAny || !running || publish) begin
      tickCount <= 6'h00;
    end else if (modulatorClock) begin
      tickCount <= 6'(tickCount + 6'h01);
    end
  end

  // Helper: registers folded in the current pass
  logic [4:0] foldCount;
  always_ff @(posedge mclk) begin
    if (rstAny || clearCrc) begin
      foldCount <= 5'h00;
    end else if (stepCrc) begin
      foldCount <= 5'(foldCount + 5'h01);
    end
  end

  a_unlocked_zero: assert property (
    (!locked && $past(!locked)) |-> (configChecksum == 16'h0000) && !mismatch)
    else $error("checksum or flag not clear while unlocked");

  a_reset_key: assert property (
    $rose(hardRstN) |-> (lockField == cmcm_pkg::LOCK_KEY) && !mapLocked)
    else $error("lock field not at key after reset");

  a_pass_period: assert property (
    sPublish |-> (tickCount == 6'h18))
    else $error("pass did not publish on its 25th tick");

  a_publish_value: assert property (
    sPublish ##0 !lockWrite |=> (configChecksum == $past(crcOut))
      && (lockAndConfigChecksum[15:0] == $past(crcOut)))
    else $error("published checksum not stored in 0x1F");

  a_ref_capture: assert property (
    (sPublish ##0 !refValid) |=> refValid && (refValue == configChecksum))
    else $error("first result not latched as reference");

  a_ref_stable: assert property (
    (refValid && locked && !lockWrite) |=> (refValue == $past(refValue)))
    else $error("reference changed while locked");

  a_mismatch_set: assert property (
    sPublishBad |=> mismatch ##0 !dataReadyN)
    else $error("mismatch not flagged on the pin");

  a_disabled_quiet: assert property (
    (sPublish ##0 !enInt ##0 !mismatch) |=> !mismatch)
    else $error("flag raised with interrupt disabled");

  a_flag_hold: assert property (
    (mismatch && !lockWrite) |=> mismatch [*2] or (mismatch ##1 !locked))
    else $error("mismatch flag dropped while locked");

  a_unlock_release: assert property (
    sUnlockWrite |=> !mismatch && !mapLocked && (dataReadyN == $past(readyPulseN)))
    else $error("unlock did not release the pin");

  a_write_gate: assert property (
    (locked && !lockWrite) |=> mapLocked)
    else $error("map not reported locked");

  a_slot_range: assert property (
    slot <= cmcm_pkg::PUBLISH_SLOT)
    else $error("slot counter out of range");

  a_power_clear: assert property (
    $rose(nrst) |-> (lockField == cmcm_pkg::LOCK_KEY) && !mismatch && dataReadyN)
    else $error("power-on state not unlocked and quiet");

  a_idle_clear: assert property (
    !running |=> (crcOut == cmcm_pkg::CRC_INIT) && (slot == 5'h00))
    else $error("engine kept state while stopped");

  a_idle_no_fold: assert property (
    !locked |-> !stepCrc && !publish)
    else $error("checksum work while unlocked");

  a_sum_hold: assert property (
    (locked && !lockWrite && !publish) |=> $stable(configChecksum))
    else $error("checksum changed between publishes");

  a_reg_mirror: assert property (
    lockAndConfigChecksum == {lockField, configChecksum})
    else $error("0x1F output out of step with its fields");

  a_fold_count: assert property (
    sPublish |-> (foldCount == cmcm_pkg::NUM_REGS))
    else $error("pass did not fold every register");

  // Address walk: lowest first, parked at the tail
  a_first_addr: assert property (
    (running && (slot == 5'h00)) |-> (mapAddr == cmcm_pkg::ADDR_FIRST))
    else $error("pass did not start at the lowest address");

  a_addr_step: assert property (
    (stepCrc && (slot < cmcm_pkg::NUM_REGS - 5'h01)) |=> (mapAddr == 5'($past(mapAddr) + 5'h01)))
    else $error("message address did not advance by one");

  a_last_addr: assert property (
    (slot >= cmcm_pkg::NUM_REGS - 5'h01) |-> (mapAddr == cmcm_pkg::ADDR_LOCK))
    else $error("tail of the pass not parked on 0x1F");

  a_lock_word_zero: assert property (
    isLockReg |-> (msgWord[15:0] == 16'h0000))
    else $error("checksum bits not masked out of the message");

  a_ready_ones: assert property (
    isStatusReg |-> (msgWord[cmcm_pkg::READY_LSB +: 8] == 8'hFF))
    else $error("ready flags not forced to ones");

  // Pin and flag coupling
  a_pin_low: assert property (
    mismatch |-> !dataReadyN)
    else $error("flag set but pin not low");

  a_flag_locked: assert property (
    mismatch |-> locked)
    else $error("flag pending while unlocked");

  a_pin_follow: assert property (
    sQuietCycle |-> (dataReadyN == $past(readyPulseN)))
    else $error("pin not following ready level");

  a_rise_cause: assert property (
    $rose(mismatch) |-> $past(publish) && $past(refValid) && $past(enInt))
    else $error("flag raised without a failed compare");

  a_write_drops_ref: assert property (
    lockWrite |=> !refValid)
    else $error("processed 0x1F write kept the old reference");

  a_ref_unlocked: assert property (
    !locked |-> !refValid)
    else $error("reference kept while unlocked");

  a_relock_restart: assert property (
    sRelockWrite |=> mapLocked && (slot == 5'h00) && (crcOut == cmcm_pkg::CRC_INIT))
    else $error("lock write did not restart the pass");

  a_unlock_zero_reg: assert property (
    sUnlockWrite |=> (lockAndConfigChecksum[15:0] == 16'h0000) && (configChecksum == 16'h0000))
    else $error("unlock did not clear the checksum field");

  a_tick_bound: assert property (
    tickCount <= 6'h18)
    else $error("pass ran past its 25th tick");
endmodule
`default_nettype wire

// ---- include/cmcm_pkg.sv ----
// Function
// - Checksum of config map lands in 0x1F
// - Engine runs only while lock field differs from key
// - Unlocked: checksum held zero, no computing
// - Pass completes and repeats every 25 ticks
// - Power-on or hard reset clears checksum
// - Message covers registers 0x09 through 0x1F
// - Ready flags as ones, checksum as zeros
// - Enabled interrupt flags unwritten config change
// - Interrupt drives data-ready pin low
// - Unlocking clears interrupt and releases pin
// - Powers up unlocked with no interrupt
// - First result after lock becomes reference
// - Later results compared against reference
// - Mismatch holds pin low until cleared
// - Locked map ignores writes except 0x1F
// - Lock field resets to key 0xA5
package cmcm_pkg;
  localparam logic [4:0]  ADDR_FIRST       = 5'h09;
  localparam logic [4:0]  ADDR_LOCK        = 5'h1F;
  localparam logic [4:0]  ADDR_STATUS_COMM = 5'h0A;
  localparam int          READY_LSB        = 16;
  localparam logic [23:0] READY_MASK       = 24'hFF0000;
  localparam logic [7:0]  LOCK_KEY         = 8'hA5;
  localparam logic [15:0] CRC_POLY         = 16'h8005;
  localparam logic [15:0] CRC_INIT         = 16'h0000;
  localparam logic [15:0] CHECKSUM_RESET   = 16'h0000;
  localparam int          LOCK_LSB         = 16;
  localparam logic [4:0]  NUM_REGS         = 5'h17;
  localparam logic [4:0]  PASS_TICKS       = 5'h19;
  localparam logic [4:0]  PUBLISH_SLOT     = 5'h18;
  localparam int          REG_WIDTH        = 24;
endpackage

// ---- hdl/cmcm_crc_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmcm_crc_engine #(
  parameter int WIDTH = cmcm_pkg::REG_WIDTH
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] word,
  output logic      [15:0]      crc
);
  // Bit-serial equivalent, folded over one register per tick
  function automatic logic [15:0] crcFold(input logic [15:0] c, input logic [WIDTH-1:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? cmcm_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  wire logic [15:0] folded = crcFold(crc, word);

  always_ff @(posedge mclk) begin
    if (!nrst || clear) begin
      crc <= cmcm_pkg::CRC_INIT;
    end else if (step) begin
      crc <= folded;
    end
  end
endmodule
`default_nettype wire

// ---- sim/cmcm_host_map_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmcm_host_map_model (
  input  wire logic        mclk,
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [23:0] wrData,
  input  wire logic        mapLocked,
  input  wire logic [4:0]  mapAddr,
  output logic      [23:0] mapData
);
  logic [23:0] mem [0:31];
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 24'h5A3C96 ^ {3{i[7:0]}};
    end
  end
  assign mapData = mem[mapAddr];
  // Plain always so the bench may upset cells to mimic corruption
  always @(posedge mclk) begin
    if (wrEn && (!mapLocked || wrAddr == 5'h1F)) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule
`default_nettype wire

// ---- sim/cmcm_config_map_crc_monitor_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t %s", $time, m); end end
module cmcm_config_map_crc_monitor_bench;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        hardRstN = 1'b1;
  logic        modulatorClock = 1'b0;
  logic        enInt = 1'b0;
  logic        readyPulseN = 1'b1;
  logic        wrEn = 1'b0;
  logic [4:0]  wrAddr = 5'h00;
  logic [23:0] wrData = 24'h000000;
  logic [23:0] mapData;
  logic [4:0]  mapAddr;
  logic [23:0] lockAndConfigChecksum;
  logic        mapLocked;
  logic        mismatch;
  logic        dataReadyN;
  int          n_mismatch = 0;
  int          total_checks = 0;

  cmcm_config_map_crc_monitor cmcm_config_map_crc_monitor_i (.mclk(mclk), .nrst(nrst),
    .hardRstN(hardRstN), .modulatorClock(modulatorClock), .enInt(enInt),
    .readyPulseN(readyPulseN), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .mapData(mapData), .mapAddr(mapAddr), .lockAndConfigChecksum(lockAndConfigChecksum),
    .mapLocked(mapLocked), .mismatch(mismatch), .dataReadyN(dataReadyN));
  cmcm_host_map_model cmcm_host_map_model_i (.mclk(mclk), .wrEn(wrEn), .wrAddr(wrAddr),
    .wrData(wrData), .mapLocked(mapLocked), .mapAddr(mapAddr), .mapData(mapData));

  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Tick every second cycle keeps a pass at 50 cycles
  always @(negedge mclk) modulatorClock <= ~modulatorClock;

  function automatic logic [15:0] exp_crc();
    logic [15:0] c;
    logic [23:0] w;
    c = 16'h0000;
    for (int a = 9; a < 32; a++) begin
      w = cmcm_host_map_model_i.mem[a];
      if (a == 10) w[23:16] = 8'hFF;
      if (a == 31) w[15:0] = 16'h0000;
      for (int b = 23; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? cmcm_pkg::CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    wrEn = 1'b1;
    wrAddr = a;
    wrData = d;
    cyc(1);
    wrEn = 1'b0;
    cyc(1);
  endtask

  task automatic t_reset();
    `CHK(lockAndConfigChecksum, 24'hA50000, "reset reg")
    `CHK({mapLocked, mismatch, dataReadyN}, 3'b001, "reset flags")
    `CHK(mapAddr, 5'h09, "reset addr")
  endtask

  task automatic t_lock();
    enInt = 1'b1;
    for (int a = 9; a < 31; a++) wr(a[4:0], 24'(24'h123456 + a));
    wr(5'h1F, 24'h000000);
    `CHK(mapLocked, 1'b1, "lock")
    cyc(40);
    `CHK(lockAndConfigChecksum, 24'h000000, "early publish")
    cyc(20);
    `CHK(lockAndConfigChecksum, {8'h00, exp_crc()}, "first sum")
    `CHK(dataReadyN, 1'b1, "no false flag")
  endtask

  task automatic t_upset(input logic ie, input int a);
    enInt = ie;
    cmcm_host_map_model_i.mem[a] = cmcm_host_map_model_i.mem[a] ^ 24'h000100;
    cyc(110);
    `CHK(lockAndConfigChecksum[15:0], exp_crc(), "new sum")
    `CHK(mismatch, ie, "flag")
    `CHK(dataReadyN, ~ie, "pin")
    readyPulseN = 1'b0;
    cyc(1);
    readyPulseN = 1'b1;
    cyc(1);
    `CHK(dataReadyN, ~ie, "pin held over ready pulse")
  endtask

  task automatic t_unlock();
    wr(5'h1F, 24'hA50000);
    `CHK({mismatch, dataReadyN, mapLocked}, 3'b010, "unlock clear")
    cyc(60);
    `CHK(lockAndConfigChecksum, 24'hA50000, "no sum unlocked")
  endtask

  task automatic t_pass_and_hard();
    readyPulseN = 1'b0;
    cyc(1);
    `CHK(dataReadyN, 1'b0, "pass through")
    readyPulseN = 1'b1;
    hardRstN = 1'b0;
    cyc(2);
    hardRstN = 1'b1;
    `CHK({lockAndConfigChecksum, mapLocked}, {24'hA50000, 1'b0}, "hard reset")
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(12);
    nrst = 1'b1;
    t_reset();
    t_lock();
    t_upset(1'b1, 12);
    t_unlock();
    t_lock();
    t_upset(1'b0, 20);
    t_pass_and_hard();
    finish_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
